// [rtl/tpc_parity.sv]
// Odd parity checker for punched codes
`timescale 1ns/100ps
module tpc_parity #(
    parameter int WIDTH = 8
) (
    input  wire logic [WIDTH-1:0] code,
    output wire logic             odd
);
    import tpc_pkg::*;

    assign odd = ^code;

endmodule : tpc_parity

// [rtl/tpc_pkg.sv]
// Types shared by the tape punch control block
package tpc_pkg;

    // Punch mode switch positions
    typedef enum logic [1:0] {
        MODE_OFF = 2'h0,
        MODE_SEL = 2'h1,
        MODE_ALL = 2'h2
    } tpc_mode_t;

    // Kind of keyboard operation
    typedef enum logic [2:0] {
        KEY_CHAR      = 3'h0,
        KEY_PUNCH_ON  = 3'h1,
        KEY_AUX_ON    = 3'h2,
        KEY_ALL_OFF   = 3'h4
    } tpc_key_t;

endpackage : tpc_pkg

// [rtl/tpc_regs.svh]
// Register map, field positions, reset values and rate constants for tape punch control
`ifndef TPC_REGS_SVH
`define TPC_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define TPC_OFF_CTRL        8'h00
`define TPC_OFF_STATE       8'h04
`define TPC_OFF_IRQ_STATUS  8'h08
`define TPC_OFF_IRQ_MASK    8'h0C
`define TPC_OFF_PROG_KEYS   8'h10

// ****************************************
// Field positions
// ****************************************
`define TPC_CTRL_MODE_LSB   0
`define TPC_CTRL_READ_EN    2
`define TPC_CTRL_FC_EXIT    3
`define TPC_ST_PUNCH_ON     0
`define TPC_ST_AUX_ON       1
`define TPC_ST_FIELD_CTRL   2
`define TPC_ST_NEED_OFF     3
`define TPC_ST_PUNCH_BUSY   4
`define TPC_IRQ_PARITY      0
`define TPC_IRQ_ON_BLOCKED  1
`define TPC_IRQ_FIELD_ENTER 2
`define TPC_IRQ_W           3

// ****************************************
// Reset values and responses
// ****************************************
`define TPC_RST_MODE        2'h0
`define TPC_RST_IRQ_MASK    3'h0
`define TPC_RESP_OKAY       2'h0
`define TPC_RESP_SLVERR     2'h2

// ****************************************
// Rates in codes per minute, clock in Hz
// ****************************************
`define TPC_CLK_HZ          64'h0000_0000_05F5_E100
`define TPC_READ_CPM        572
`define TPC_PUNCH_CPM       1000
`define TPC_PAIR_CPM        1200
`define TPC_CYC_DN(cpm)     ((64'd60 * `TPC_CLK_HZ) / (cpm))
`define TPC_CYC_UP(cpm)     ((64'd60 * `TPC_CLK_HZ + (cpm) - 1) / (cpm))

`endif

// [rtl/tpc_top.sv]
// Tape punch control: keylever, field and processor control of the punches
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "tpc_regs.svh"

// What this block does
// RULE1: Control keys punch codes only in all mode
// RULE2: Select mode: control keys act, punch nothing
// RULE3: Off mode: control keys do nothing
// RULE4: Punch-on key turns punch on in select
// RULE5: Aux-on key turns aux on if connected
// RULE6: Off key turns both punches off
// RULE7: Field channels: punch on, aux on, off, off
// RULE8: Field channels act only under field control
// RULE9: Field-control key enters field control
// RULE10: Processor instruction enters field control directly
// RULE11: After field control, off before any on
// RULE12: Reader advances 572 codes per minute
// RULE13: Punch paces 1000 per minute, pairs 1200
// RULE14: Codes are eight bits, channels 8 to 1
// RULE15: Punched codes checked for odd parity
// RULE16: Sixteen program keys decoded into groups
// RULE17: All punches everything, off nothing, select switched
// RULE18: Punch, aux and field flags cleared at reset
module tpc_top #(
    parameter int ADDR_W   = 8,
    parameter int READ_CYC = int'(`TPC_CYC_DN(`TPC_READ_CPM)),
    parameter int SUST_CYC = int'(`TPC_CYC_UP(`TPC_PUNCH_CPM)),
    parameter int PAIR_CYC = int'(`TPC_CYC_UP(`TPC_PAIR_CPM))
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic [2:0]        awprot,
    input  wire logic              awvalid,
    output wire logic              awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output wire logic              wready,
    output logic      [1:0]        bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic [2:0]        arprot,
    input  wire logic              arvalid,
    output wire logic              arready,
    output logic      [31:0]       rdata,
    output logic      [1:0]        rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    input  wire logic              key_valid,
    output wire logic              key_ready,
    input  wire tpc_pkg::tpc_key_t key_kind,
    input  wire logic [7:0]        key_code,
    input  wire logic              field_ctrl_enter_key,
    input  wire logic              cpu_field_ctrl,
    input  wire logic [3:0]        field_ch,
    input  wire logic              aux_connected,
    input  wire logic [15:0]       prog_keys,
    output logic                   punch_strobe,
    output logic      [7:0]        punch_code,
    output logic                   aux_strobe,
    output logic      [7:0]        aux_code,
    output logic                   punch_on,
    output logic                   aux_on,
    output logic                   field_ctrl,
    output logic                   reader_advance,
    output logic      [10:0]       manual_prog_sel,
    output logic                   tape_prog_sel,
    output logic      [1:0]        prog_selector,
    output logic      [1:0]        manual_selector,
    output wire logic              irq
);
    import tpc_pkg::*;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] off);
        logic [ADDR_W-1:0] off_w;
        off_w   = ADDR_W'(off);
        reg_hit = (addr[ADDR_W-1:2] == off_w[ADDR_W-1:2]);
    endfunction : reg_hit

    localparam int          SAT_CYC = 2 * SUST_CYC;
    localparam logic [31:0] SAT32   = 32'(SAT_CYC);

    // ****************************************
    // Register state
    // ****************************************
    logic [1:0]            mode;
    logic                  read_en;
    logic [`TPC_IRQ_W-1:0] irq_status;
    logic [`TPC_IRQ_W-1:0] irq_mask;
    logic                  need_off;
    logic                  aw_held;
    logic                  w_held;
    logic [ADDR_W-1:0]     aw_addr_q;
    logic [31:0]           w_data_q;
    logic [3:0]            w_strb_q;
    logic [31:0]           since_last;
    logic [31:0]           prev_gap;
    logic [31:0]           read_cnt;

    // ****************************************
    // Bus decode
    // ****************************************
    wire do_write   = aw_held && w_held && !bvalid;
    wire wr_b0      = do_write && w_strb_q[0];
    wire wr_ctrl    = wr_b0 && reg_hit(aw_addr_q, `TPC_OFF_CTRL);
    wire wr_istat   = wr_b0 && reg_hit(aw_addr_q, `TPC_OFF_IRQ_STATUS);
    wire wr_imask   = wr_b0 && reg_hit(aw_addr_q, `TPC_OFF_IRQ_MASK);
    wire wr_mapped  = reg_hit(aw_addr_q, `TPC_OFF_CTRL) || reg_hit(aw_addr_q, `TPC_OFF_STATE)
                   || reg_hit(aw_addr_q, `TPC_OFF_IRQ_STATUS) || reg_hit(aw_addr_q, `TPC_OFF_IRQ_MASK)
                   || reg_hit(aw_addr_q, `TPC_OFF_PROG_KEYS);
    wire fc_exit    = wr_ctrl && w_data_q[`TPC_CTRL_FC_EXIT];
    wire rd_take    = arvalid && arready;
    wire rd_ctrl    = reg_hit(araddr, `TPC_OFF_CTRL);
    wire rd_state   = reg_hit(araddr, `TPC_OFF_STATE);
    wire rd_istat   = reg_hit(araddr, `TPC_OFF_IRQ_STATUS);
    wire rd_imask   = reg_hit(araddr, `TPC_OFF_IRQ_MASK);
    wire rd_keys    = reg_hit(araddr, `TPC_OFF_PROG_KEYS);
    wire rd_mapped  = rd_ctrl || rd_state || rd_istat || rd_imask || rd_keys;
    wire punch_busy = !key_ready;

    wire [31:0] ctrl_word  = {29'h0, read_en, mode};
    wire [31:0] state_word = {27'h0, punch_busy, need_off, field_ctrl, aux_on, punch_on};
    wire [31:0] rd_word    = rd_ctrl  ? ctrl_word
                           : rd_state ? state_word
                           : rd_istat ? {29'h0, irq_status}
                           : rd_imask ? {29'h0, irq_mask}
                           : rd_keys  ? {16'h0, prog_keys}
                           : 32'h0000_0000;

    assign awready = !aw_held;
    assign wready  = !w_held;
    assign arready = !rvalid;

    // ****************************************
    // Write channel
    // ****************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held   <= 1'b0;
            w_held    <= 1'b0;
            aw_addr_q <= '0;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
            bvalid    <= 1'b0;
            bresp     <= `TPC_RESP_OKAY;
        end
        else
        begin
            if (awvalid && awready)
            begin
                aw_held   <= 1'b1;
                aw_addr_q <= awaddr;
            end
            if (wvalid && wready)
            begin
                w_held   <= 1'b1;
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end
            if (do_write)
            begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
                bvalid  <= 1'b1;
                bresp   <= wr_mapped ? `TPC_RESP_OKAY : `TPC_RESP_SLVERR;
            end
            else if (bready)
            begin
                bvalid <= 1'b0;
            end
        end
    end

    // ****************************************
    // Read channel
    // ****************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= `TPC_RESP_OKAY;
        end
        else if (rd_take)
        begin
            rvalid <= 1'b1;
            rdata  <= rd_word;
            rresp  <= rd_mapped ? `TPC_RESP_OKAY : `TPC_RESP_SLVERR;
        end
        else if (rready)
        begin
            rvalid <= 1'b0;
        end
    end

    // ****************************************
    // Punch decision
    // ****************************************
    wire mode_all  = (mode == MODE_ALL);
    wire mode_sel  = (mode == MODE_SEL);
    wire key_take  = key_valid && key_ready;
    wire is_ctl    = (key_kind != KEY_CHAR);
    wire ctl_act   = key_take && is_ctl && (mode_all || mode_sel);           // RULE3
    wire want_on   = (key_kind == KEY_PUNCH_ON) || (key_kind == KEY_AUX_ON);
    wire on_block  = ctl_act && want_on && need_off;                          // RULE11
    wire key_on1   = ctl_act && !on_block && (key_kind == KEY_PUNCH_ON) && mode_sel;   // RULE4
    wire key_on2   = ctl_act && !on_block && (key_kind == KEY_AUX_ON) && aux_connected; // RULE5
    wire key_off   = ctl_act && (key_kind == KEY_ALL_OFF);                    // RULE6
    wire do_punch  = key_take && (mode_all || (mode_sel && !is_ctl && punch_on)); // RULE1 RULE2 RULE17
    wire do_aux    = key_take && !is_ctl && aux_on && aux_connected;
    wire fld_live  = field_ctrl;                                              // RULE8
    wire fld_on1   = fld_live && field_ch[0];                                 // RULE7
    wire fld_on2   = fld_live && field_ch[1] && aux_connected;
    wire fld_off1  = fld_live && field_ch[2];
    wire fld_off2  = fld_live && field_ch[3];
    wire fc_enter  = field_ctrl_enter_key || cpu_field_ctrl;                  // RULE9 RULE10

    // Keyboard acts after the field rack, so a keylever wins a tie
    wire fld_punch = fld_off1 ? 1'b0 : (fld_on1 ? 1'b1 : punch_on);
    wire fld_aux   = fld_off2 ? 1'b0 : (fld_on2 ? 1'b1 : aux_on);
    wire next_punch_on = key_off ? 1'b0 : (key_on1 ? 1'b1 : fld_punch);
    wire next_aux_on   = key_off ? 1'b0 : (key_on2 ? 1'b1 : fld_aux);
    wire next_field    = fc_enter ? 1'b1 : (fc_exit ? 1'b0 : field_ctrl);
    wire next_need_off = (field_ctrl && !next_field) ? 1'b1 : (key_off ? 1'b0 : need_off);

    // ****************************************
    // Punch pacing
    // ****************************************
    wire [32:0] pair_sum = {1'b0, prev_gap} + {1'b0, since_last};
    assign key_ready = (since_last >= 32'(PAIR_CYC)) && (pair_sum >= 33'(SAT_CYC)); // RULE13

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            since_last <= SAT32;
            prev_gap   <= SAT32;
        end
        else if (key_take)
        begin
            since_last <= 32'h0000_0001;
            prev_gap   <= since_last;
        end
        else if (since_last < SAT32)
        begin
            since_last <= since_last + 32'h0000_0001;
        end
    end

    // ****************************************
    // Control flags and code outputs
    // ****************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            punch_on   <= 1'b0;                                               // RULE18
            aux_on     <= 1'b0;
            field_ctrl <= 1'b0;
            need_off   <= 1'b0;
        end
        else
        begin
            punch_on   <= next_punch_on;
            aux_on     <= next_aux_on;
            field_ctrl <= next_field;
            need_off   <= next_need_off;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            punch_strobe <= 1'b0;
            punch_code   <= 8'h00;
            aux_strobe   <= 1'b0;
            aux_code     <= 8'h00;
        end
        else
        begin
            punch_strobe <= do_punch;
            aux_strobe   <= do_aux;
            if (do_punch)
                punch_code <= key_code;                                       // RULE14
            if (do_aux)
                aux_code <= key_code;
        end
    end

    // ****************************************
    // Parity check and interrupts
    // ****************************************
    logic code_odd;

    tpc_parity #(
        .WIDTH (8)
    ) u_parity (
        .code (punch_code),
        .odd  (code_odd)
    );

    wire [`TPC_IRQ_W-1:0] irq_evt = {fc_enter && !field_ctrl, on_block, punch_strobe && !code_odd}; // RULE15
    wire [`TPC_IRQ_W-1:0] irq_clr = wr_istat ? w_data_q[`TPC_IRQ_W-1:0] : '0;

    assign irq = |(irq_status & irq_mask);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mode       <= `TPC_RST_MODE;
            read_en    <= 1'b0;
            irq_mask   <= `TPC_RST_IRQ_MASK;
            irq_status <= '0;
        end
        else
        begin
            if (wr_ctrl)
            begin
                mode    <= w_data_q[`TPC_CTRL_MODE_LSB +: 2];
                read_en <= w_data_q[`TPC_CTRL_READ_EN];
            end
            if (wr_imask)
                irq_mask <= w_data_q[`TPC_IRQ_W-1:0];
            irq_status <= (irq_status & ~irq_clr) | irq_evt;
        end
    end

    // ****************************************
    // Reader pacing and program keys
    // ****************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            read_cnt       <= 32'h0000_0000;
            reader_advance <= 1'b0;
        end
        else
        begin
            reader_advance <= read_en && (read_cnt == 32'(READ_CYC - 1));      // RULE12
            if (!read_en || read_cnt == 32'(READ_CYC - 1))
                read_cnt <= 32'h0000_0000;
            else
                read_cnt <= read_cnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            manual_prog_sel <= 11'h000;
            tape_prog_sel   <= 1'b0;
            prog_selector   <= 2'h0;
            manual_selector <= 2'h0;
        end
        else
        begin
            manual_prog_sel <= prog_keys[10:0];                               // RULE16
            tape_prog_sel   <= prog_keys[11];
            prog_selector   <= prog_keys[13:12];
            manual_selector <= prog_keys[15:14];
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    AST_ALL_PUNCHES: // RULE1
    assert property (key_valid && key_ready && mode == MODE_ALL |=> punch_strobe && punch_code == $past(key_code))
    else $error("Key in all mode not punched");

    AST_SEL_CTL_SILENT: // RULE2
    assert property (key_valid && key_ready && key_kind != KEY_CHAR && mode == MODE_SEL |=> !punch_strobe)
    else $error("Control key punched in select mode");

    AST_OFF_INERT: // RULE3
    assert property (key_valid && key_ready && mode == MODE_OFF && !field_ctrl
                     |=> !punch_strobe && $stable(punch_on) && $stable(aux_on))
    else $error("Key had effect in off mode");

    AST_ON1: // RULE4
    assert property (key_valid && key_ready && key_kind == KEY_PUNCH_ON && mode == MODE_SEL && !need_off
                     |=> punch_on)
    else $error("Punch-on key failed to switch punch on");

    AST_ON2_NEEDS_AUX: // RULE5
    assert property (key_valid && key_ready && key_kind == KEY_AUX_ON && !aux_connected && !field_ctrl
                     |=> $stable(aux_on))
    else $error("Aux switched on with no unit connected");

    AST_OFF_BOTH: // RULE6
    assert property (key_valid && key_ready && key_kind == KEY_ALL_OFF && (mode == MODE_SEL || mode == MODE_ALL)
                     |=> !punch_on && !aux_on)
    else $error("Off key left a punch on");

    AST_FIELD_DECODE: // RULE7
    assert property (field_ctrl && field_ch == 4'h4 && !(key_valid && key_ready) |=> !punch_on)
    else $error("Field channel 3 did not switch punch off");

    AST_FIELD_IGNORED: // RULE8
    assert property (!field_ctrl && field_ch != 4'h0 && !(key_valid && key_ready)
                     |=> $stable(punch_on) && $stable(aux_on))
    else $error("Field channel acted outside field control");

    AST_FC_ENTER: // RULE9
    assert property (field_ctrl_enter_key || cpu_field_ctrl |=> field_ctrl)
    else $error("Field control not entered");

    AST_ON_AFTER_FIELD: // RULE11
    assert property (need_off && !field_ctrl && (mode == MODE_SEL || mode == MODE_ALL) && key_valid && key_ready
                     && key_kind == KEY_PUNCH_ON |=> $stable(punch_on) && irq_status[`TPC_IRQ_ON_BLOCKED])
    else $error("On code accepted before off after field control");

    AST_PUNCH_PACE: // RULE13
    assert property (key_valid && key_ready |=> !key_ready [*8])
    else $error("Punch accepted codes too close together");

    AST_PARITY_FLAG: // RULE15
    assert property (punch_strobe && !(^punch_code) |=> irq_status[`TPC_IRQ_PARITY])
    else $error("Even parity code not flagged");

    AST_PROG_KEYS: // RULE16
    assert property (##1 tape_prog_sel == $past(prog_keys[11]) && prog_selector == $past(prog_keys[13:12]))
    else $error("Program key decode wrong");

endmodule : tpc_top

// [tb/tpc_kbd.sv]
// Keyboard source model: offers one key and holds it until taken
`timescale 1ns/100ps
module tpc_kbd (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         go,
    input  wire logic [2:0]   kind_in,
    input  wire logic [7:0]   code_in,
    input  wire logic         key_ready,
    output logic              key_valid,
    output tpc_pkg::tpc_key_t key_kind,
    output logic      [7:0]   key_code
);
    import tpc_pkg::*;
    // Released code is inverted so stale bits never look valid
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            key_valid <= 1'b0;
            key_kind  <= KEY_CHAR;
            key_code  <= 8'h00;
        end
        else if (key_valid && key_ready)
        begin
            key_valid <= 1'b0;
            key_code  <= ~key_code;
        end
        else if (go && !key_valid)
        begin
            key_valid <= 1'b1;
            key_kind  <= tpc_key_t'(kind_in);
            key_code  <= code_in;
        end
    end
endmodule : tpc_kbd

// [tb/tpc_top_tb.sv]
// Self-checking bench for tape punch control
`timescale 1ns/100ps
module tpc_top_tb;
    import tpc_pkg::*;
    localparam int RC = 20;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, go, fck, cfc, auxc;
    logic        awready, wready, bvalid, arready, rvalid, key_valid, key_ready, pstb, astb;
    logic        pon, aon, fc, radv, tps, irq, epon, eaon, hit;
    logic [1:0]  bresp, rresp, rr, psel, msel;
    logic [2:0]  kkind;
    logic [3:0]  fch;
    logic [7:0]  awaddr, araddr, kcode, pcode, acode, key_code, c;
    logic [10:0] mps;
    logic [15:0] pk;
    logic [31:0] wdata, rdata, rdv;
    tpc_key_t    key_kind;
    tpc_mode_t   md;
    int          fail_count, compares, seed, cyc, n;
    tpc_key_t    seq [5] = '{KEY_PUNCH_ON, KEY_CHAR, KEY_AUX_ON, KEY_CHAR, KEY_ALL_OFF};
    logic [1:0]  ftab [4] = '{2'h1, 2'h3, 2'h2, 2'h0};

    tpc_top #(.READ_CYC(RC), .SUST_CYC(10), .PAIR_CYC(9)) dut_u (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .key_valid(key_valid), .key_ready(key_ready), .key_kind(key_kind),
        .key_code(key_code), .field_ctrl_enter_key(fck), .cpu_field_ctrl(cfc), .field_ch(fch),
        .aux_connected(auxc), .prog_keys(pk), .punch_strobe(pstb), .punch_code(pcode),
        .aux_strobe(astb), .aux_code(acode), .punch_on(pon), .aux_on(aon), .field_ctrl(fc),
        .reader_advance(radv), .manual_prog_sel(mps), .tape_prog_sel(tps),
        .prog_selector(psel), .manual_selector(msel), .irq(irq));

    tpc_kbd kbd_u (.aclk(aclk), .aresetn(aresetn), .go(go), .kind_in(kkind), .code_in(kcode),
        .key_ready(key_ready), .key_valid(key_valid), .key_kind(key_kind), .key_code(key_code));

    // ****
    // Tasks
    // ****
    task automatic print_verdict();
        $display("Counts: %0d compares, %0d mismatches", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (!bvalid);
        rr = bresp;
        bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'b0;
        end while (!rvalid);
        rdv = rdata;
        rr  = rresp;
        rready <= 1'b0;
    endtask : axi_rd

    task automatic press(input logic [2:0] k, input logic [7:0] d);
        @(posedge aclk);
        go    <= 1'b1;
        kkind <= k;
        kcode <= d;
        do
        begin
            @(posedge aclk);
            go <= 1'b0;
        end while (!(key_valid && key_ready));
        #1;
    endtask : press

    task automatic fp(input logic [3:0] ch, input logic e, input logic p);
        @(posedge aclk);
        fch <= ch;
        fck <= e;
        cfc <= p;
        @(posedge aclk);
        fch <= 4'h0;
        fck <= 1'b0;
        cfc <= 1'b0;
        repeat (2) @(posedge aclk);
        #1;
    endtask : fp

    // ****
    // Clock and hang guard
    // ****
    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            print_verdict();
        end
    end

    // ****
    // Main sequence
    // ****
    initial
    begin
        seed = 9090;
        {aresetn, awvalid, wvalid, bready, arvalid, rready, go, fck, cfc, auxc, epon, eaon} = '0;
        {awaddr, araddr, kkind, kcode, fch, pk, wdata} = '0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(8'h04);
        chk(rdv, 0);
        axi_rd(8'h0C);
        chk(rdv, 0);
        chk({fc, aon, pon}, 0);
        axi_rd(8'h14);
        chk(rdv, 0);
        chk(rr, 2);
        axi_wr(8'h14, 32'h4);
        chk(rr, 2);
        $display("test reset and map done");
        for (int m = 0; m < 8; m++)
        begin
            md = tpc_mode_t'((m + 3) % 4);
            @(posedge aclk);
            auxc <= (m > 3);
            axi_wr(8'h00, {30'h0, md});
            for (int i = 0; i < 5; i++)
            begin
                c = 8'($random(seed));
                c[7] = c[7] ^ ~(^c);
                press(seq[i], c);
                hit = md == MODE_ALL || (md == MODE_SEL && seq[i] == KEY_CHAR && epon);
                chk(pstb, hit);
                if (hit)
                    chk(pcode, c);
                chk(astb, seq[i] == KEY_CHAR && eaon);
                if (seq[i] == KEY_CHAR && eaon)
                    chk(acode, c);
                if (md == MODE_SEL || md == MODE_ALL)
                begin
                    epon = (epon || (md == MODE_SEL && seq[i] == KEY_PUNCH_ON)) && seq[i] != KEY_ALL_OFF;
                    eaon = (eaon || (auxc && seq[i] == KEY_AUX_ON)) && seq[i] != KEY_ALL_OFF;
                end
                chk({aon, pon}, {eaon, epon});
            end
        end
        $display("test keylevers done");
        axi_wr(8'h0C, 32'h1);
        press(KEY_CHAR, 8'h03);
        axi_rd(8'h08);
        chk(rdv[0], 1);
        chk(irq, 1);
        axi_wr(8'h08, 32'h1);
        press(KEY_CHAR, 8'h07);
        axi_rd(8'h08);
        chk(rdv[0], 0);
        chk(irq, 0);
        $display("test parity done");
        axi_wr(8'h00, 32'h1);
        fp(4'h1, 0, 0);
        chk({fc, pon}, 0);
        fp(4'h0, 1, 0);
        chk(fc, 1);
        for (int i = 0; i < 4; i++)
        begin
            fp(4'(1 << i), 0, 0);
            chk({aon, pon}, ftab[i]);
        end
        axi_wr(8'h00, 32'h9);
        axi_rd(8'h04);
        chk(rdv[3:2], 2'h2);
        fp(4'h0, 0, 1);
        chk(fc, 1);
        axi_wr(8'h00, 32'h9);
        press(KEY_PUNCH_ON, 8'h01);
        chk(pon, 0);
        axi_rd(8'h08);
        chk(rdv[1], 1);
        press(KEY_ALL_OFF, 8'h0B);
        press(KEY_PUNCH_ON, 8'h01);
        chk(pon, 1);
        $display("test field control done");
        axi_wr(8'h00, 32'h4);
        n = 0;
        repeat (5 * RC)
        begin
            @(posedge aclk);
            n += radv;
        end
        chk(n, 5);
        $display("test reader done");
        repeat (4)
        begin
            @(posedge aclk);
            pk <= 16'($random(seed));
            repeat (2) @(posedge aclk);
            #1;
            chk({msel, psel, tps, mps}, pk);
            axi_rd(8'h10);
            chk(rdv, pk);
        end
        $display("test program keys done");
        print_verdict();
    end
endmodule : tpc_top_tb
